// >>> rtl/dvf_view_filter.v
// Access-view filter for the debug peripheral bus.
// Assumes software and debugger requests are single-cycle, same-clock, and
// that the debugger port has priority when both request together.
`timescale 1ns/10ps
`default_nettype none
`include "dvf_consts.vh"
// Functional notes
// - Software accesses get top address bit low.
// - Lower half internal, upper half external view.
// - Debugger low-half accesses handled as internal.
// - Privileged software reaches debug registers unless the debugger requests in the same cycle.
// - Non-secure state never causes the filter to block software.
// - Uncached system rejects unprivileged software accesses.
// - Debug disabled by authentication, registers stay accessible.
// - Auth input tied, fused, or module driven.
// - Auth module reachable while debug disabled.
// - Challenge-response uses random source or key.
module dvf_view_filter
(
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire        sw_req_in,
  input  wire        sw_write_in,
  input  wire        sw_priv_in,
  input  wire        sw_nonsecure_in,
  input  wire [31:0] sw_addr_in,
  input  wire [31:0] sw_wdata_in,
  output wire        sw_ready_out,
  output reg         sw_error_out,
  output reg  [31:0] sw_rdata_out,
  input  wire        dap_req_in,
  input  wire        dap_write_in,
  input  wire [31:0] dap_addr_in,
  input  wire [31:0] dap_wdata_in,
  output wire        dap_ready_out,
  output reg  [31:0] dap_rdata_out,
  input  wire [7:0]  auth_mode_in,
  input  wire [3:0]  auth_fuse_in,
  input  wire        cached_system_in,
  input  wire [31:0] device_key_in,
  output reg         bus_sel_out,
  output reg         bus_write_out,
  output reg  [31:0] debug_bus_address_out,
  output reg  [31:0] bus_wdata_out,
  output reg         bus_external_out,
  input  wire [31:0] bus_rdata_in,
  output wire [3:0]  debug_enable_out
);
  // ==========================================================================
  // Input synchronisers for fuse levels
  // ==========================================================================
  // Fuse levels are asynchronous pins, so two flops guard against metastability.
  reg [3:0] fuse_meta_reg;
  reg [3:0] fuse_sync_reg;
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fuse_meta_reg <= 4'h0;
      fuse_sync_reg <= 4'h0;
    end
    else
    begin
      fuse_meta_reg <= auth_fuse_in;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // ==========================================================================
  // Request arbitration and view selection
  // ==========================================================================
  function is_auth_addr;
    input [31:0] a;
    begin
      is_auth_addr = ((a & `DVF_AUTH_MASK) == `DVF_AUTH_BASE);
    end
  endfunction

  wire        dap_go   = dap_req_in;
  wire        sw_go    = sw_req_in && !dap_req_in;
  // Privilege checked only in uncached systems; security state is never used.
  wire        sw_deny  = !cached_system_in && !sw_priv_in;
  wire [31:0] sw_addr  = {1'b0, sw_addr_in[30:0]};
  reg  [31:0] sel_addr;
  reg         sel_wr;
  reg  [31:0] sel_wd;
  always @*
  begin
    if (dap_go)
    begin
      // The debugger keeps its top bit, so it may choose either view.
      sel_addr = dap_addr_in;
      sel_wr   = dap_write_in;
      sel_wd   = dap_wdata_in;
    end
    else
    begin
      sel_addr = sw_addr;
      sel_wr   = sw_write_in;
      sel_wd   = sw_wdata_in;
    end
  end
  wire        pass     = dap_go || (sw_go && !sw_deny);
  wire        hit_auth = pass && is_auth_addr(sel_addr);
  wire        fwd      = pass && !hit_auth;
  wire [31:0] auth_rdata;
  wire        auth_unlocked;

  // ==========================================================================
  // Ready outputs
  // ==========================================================================
  // The debugger wins a tie; the losing software request is refused, not queued.
  assign sw_ready_out  = !dap_req_in;
  assign dap_ready_out = 1'b1;

  // ==========================================================================
  // Forwarded access
  // ==========================================================================
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bus_sel_out           <= 1'b0;
      bus_write_out         <= 1'b0;
      debug_bus_address_out <= 32'h00000000;
      bus_wdata_out         <= 32'h00000000;
      bus_external_out      <= 1'b0;
      sw_error_out          <= 1'b0;
    end
    else
    begin
      // Register accesses are never gated by authentication state.
      bus_sel_out  <= fwd;
      sw_error_out <= sw_go && sw_deny;
      // Address and data hold between accesses to save toggling on the far side.
      if (fwd)
      begin
        bus_write_out         <= sel_wr;
        debug_bus_address_out <= sel_addr;
        bus_wdata_out         <= sel_wd;
        bus_external_out      <= sel_addr[`DVF_VIEW_BIT];
      end
    end
  end

  // ==========================================================================
  // Read return path
  // ==========================================================================
  // Read data is steered by who asked one cycle earlier, so reads may run back to back.
  reg rd_dap_reg;
  reg rd_sw_reg;
  reg rd_auth_reg;
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_dap_reg  <= 1'b0;
      rd_sw_reg   <= 1'b0;
      rd_auth_reg <= 1'b0;
    end
    else
    begin
      rd_dap_reg  <= dap_go && !dap_write_in;
      rd_sw_reg   <= sw_go && !sw_deny && !sw_write_in;
      rd_auth_reg <= hit_auth;
    end
  end
  wire [31:0] ret_data = rd_auth_reg ? auth_rdata : bus_rdata_in;
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sw_rdata_out  <= 32'h00000000;
      dap_rdata_out <= 32'h00000000;
    end
    else
    begin
      if (rd_sw_reg)
        sw_rdata_out <= ret_data;
      if (rd_dap_reg)
        dap_rdata_out <= ret_data;
    end
  end

  // ==========================================================================
  // Authentication unit and enable selection
  // ==========================================================================
  dvf_auth_gate u_auth
  (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .sel_in        (hit_auth),
    .write_in      (sel_wr),
    .word_in       (sel_addr[5:2]),
    .wdata_in      (sel_wd),
    .device_key_in (device_key_in),
    .rdata_out     (auth_rdata),
    .unlocked_out  (auth_unlocked)
  );

  function enable_pick;
    input [1:0] mode;
    input       fuse_bit;
    input       unlocked;
    begin
      case (mode)
        `DVF_AUTH_TIED_LOW:  enable_pick = 1'b0;
        `DVF_AUTH_TIED_HIGH: enable_pick = 1'b1;
        `DVF_AUTH_FUSE:      enable_pick = fuse_bit;
        `DVF_AUTH_MODULE:    enable_pick = unlocked;
        default:             enable_pick = 1'b0;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `DVF_NUM_AUTH; gi = gi + 1)
    begin : g_en
      assign debug_enable_out[gi] = enable_pick(auth_mode_in[2*gi+1:2*gi], fuse_sync_reg[gi],
                                                auth_unlocked);
    end
  endgenerate
endmodule // dvf_view_filter
`default_nettype wire

// >>> rtl/dvf_consts.vh
// Constants for the debug bus access-view filter.
// Assumes a 32-bit debug peripheral bus address with the view bit at the top.
`ifndef DVF_CONSTS_VH
`define DVF_CONSTS_VH
`define DVF_ADDR_W          32
`define DVF_VIEW_BIT        31
`define DVF_NUM_AUTH        4
`define DVF_AUTH_TIED_LOW   2'h0
`define DVF_AUTH_TIED_HIGH  2'h1
`define DVF_AUTH_FUSE       2'h2
`define DVF_AUTH_MODULE     2'h3
`define DVF_AUTH_BASE       32'h0000F000
`define DVF_AUTH_MASK       32'h7FFFF000
`define DVF_CHAL_SEED       32'h1D872B41
`endif

// >>> rtl/dvf_auth_gate.v
// Authentication unit: challenge-response gate for the debug enable outputs.
// Assumes it sits on the filtered debug bus and is reachable at all times.
`timescale 1ns/10ps
`default_nettype none
module dvf_auth_gate
(
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire        sel_in,
  input  wire        write_in,
  input  wire [3:0]  word_in,
  input  wire [31:0] wdata_in,
  input  wire [31:0] device_key_in,
  output reg  [31:0] rdata_out,
  output wire        unlocked_out
);
  // ==========================================================================
  // Challenge source and response check
  // ==========================================================================
  reg [31:0] lfsr_reg;
  reg [31:0] challenge_reg;
  reg        unlocked_reg;
  wire [31:0] lfsr_next = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
  wire [31:0] expected  = challenge_reg ^ device_key_in;
  wire        wr_chal   = sel_in && write_in && (word_in == 4'h0);
  wire        wr_resp   = sel_in && write_in && (word_in == 4'h1);
  wire        wr_lock   = sel_in && write_in && (word_in == 4'h2);
  assign unlocked_out = unlocked_reg;
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lfsr_reg      <= `DVF_CHAL_SEED;
      challenge_reg <= 32'h00000000;
      unlocked_reg  <= 1'b0;
      rdata_out     <= 32'h00000000;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
      if (wr_chal)
      begin
        // A new challenge always relocks, so a stale response cannot be replayed.
        challenge_reg <= lfsr_reg;
        unlocked_reg  <= 1'b0;
      end
      else if (wr_resp)
        unlocked_reg <= (wdata_in == expected);
      else if (wr_lock)
        unlocked_reg <= 1'b0;
      case (word_in)
        4'h0:    rdata_out <= challenge_reg;
        4'h3:    rdata_out <= {31'h00000000, unlocked_reg};
        default: rdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule // dvf_auth_gate
`default_nettype wire

// >>> test/dvf_view_filter_properties.sv
// Checker for the debug bus access-view filter.
// Assumes it is bound to dvf_view_filter and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "dvf_consts.vh"
// ==========================================================
// Checker
module dvf_view_checker
(
  input wire logic        clk_in, arst_n_in, sw_req_in, sw_write_in, sw_priv_in, sw_nonsecure_in,
  input wire logic        dap_req_in, cached_system_in, sw_error_out, bus_sel_out, bus_external_out,
  input wire logic [31:0] sw_addr_in, dap_addr_in, debug_bus_address_out, bus_rdata_in, sw_rdata_out,
  input wire logic [7:0]  auth_mode_in,
  input wire logic [3:0]  debug_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Accesses to the authentication unit are never forwarded, so they are excluded.
  wire sw_plain  = (sw_addr_in & `DVF_AUTH_MASK) != `DVF_AUTH_BASE;
  wire dap_plain = (dap_addr_in & `DVF_AUTH_MASK) != `DVF_AUTH_BASE;
  sequence sw_ok;
    sw_req_in && !dap_req_in && sw_plain && (sw_priv_in || cached_system_in);
  endsequence
  sequence dap_take;
    dap_req_in && dap_plain;
  endsequence
  sw_low_a: assert property (sw_ok |=> bus_sel_out && debug_bus_address_out == {1'b0, $past(sw_addr_in[30:0])})
    else $error("software access not forced low");
  dap_pass_a: assert property (dap_take |=> bus_sel_out && debug_bus_address_out == $past(dap_addr_in))
    else $error("debugger address altered");
  view_flag_a: assert property (bus_sel_out |-> bus_external_out == debug_bus_address_out[31])
    else $error("view flag wrong");
  dap_low_a: assert property (dap_take ##0 !dap_addr_in[31] |=> bus_sel_out && !bus_external_out)
    else $error("low debugger access not internal");
  unpriv_drop_a: assert property (sw_req_in && !dap_req_in && sw_plain && !sw_priv_in && !cached_system_in
    |=> sw_error_out && !bus_sel_out)
    else $error("unprivileged access not rejected");
  nonsec_ok_a: assert property (sw_ok ##0 sw_nonsecure_in |=> bus_sel_out && !sw_error_out)
    else $error("non-secure access blocked");
  sw_read_a: assert property (sw_ok ##0 !sw_write_in |-> ##2 sw_rdata_out == $past(bus_rdata_in))
    else $error("software read data wrong");
  tie_low_a: assert property (auth_mode_in[1:0] == `DVF_AUTH_TIED_LOW |-> !debug_enable_out[0])
    else $error("tied low enable set");
  tie_high_a: assert property (auth_mode_in[3:2] == `DVF_AUTH_TIED_HIGH |-> debug_enable_out[1])
    else $error("tied high enable clear");
endmodule // dvf_view_checker
bind dvf_view_filter dvf_view_checker u_dvf_view_checker (.*);
`default_nettype wire

// >>> test/dvf_bus_model.sv
// Debug component register model on the far side of the filter.
// Assumes zero-wait reads, looked at while the select pulse is high.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Model
module dvf_bus_model
(
  input  wire logic        clk_in, sel_in, write_in,
  input  wire logic [31:0] addr_in, wdata_in,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem_reg [0:31];
  logic [31:0] last_reg = 32'h0;
  // The view bit picks a separate bank, so each half is seen on its own.
  wire  [4:0]  idx = {addr_in[31], addr_in[5:2]};
  // Idle data is the inverse of the last value so stale reads show up.
  assign rdata_out = (sel_in && !write_in) ? mem_reg[idx] : ~last_reg;
  always @(posedge clk_in)
  begin
    if (sel_in && write_in)
      mem_reg[idx] <= wdata_in;
    last_reg <= rdata_out;
  end
endmodule // dvf_bus_model
`default_nettype wire

// >>> test/dvf_view_filter_bench.sv
// Self-checking bench for the debug bus access-view filter.
// Assumes the register model answers on the filtered bus.
`timescale 1ns/10ps
`default_nettype none
`include "dvf_consts.vh"
// ==========================================================
// Bench
module dvf_view_filter_bench;
  logic clk_in = 1'b0, arst_n_in = 1'b0, sw_req_in = 1'b0, sw_write_in = 1'b0, sw_priv_in = 1'b0;
  logic sw_nonsecure_in = 1'b0, dap_req_in = 1'b0, dap_write_in = 1'b0, cached_system_in = 1'b0;
  logic [31:0] sw_addr_in = 32'h0, sw_wdata_in = 32'h0, dap_addr_in = 32'h0, dap_wdata_in = 32'h0;
  logic [31:0] device_key_in = 32'h000000A5, bus_rdata_in, ch;
  logic [7:0]  auth_mode_in = 8'h00;
  logic [3:0]  auth_fuse_in = 4'hF;
  wire logic sw_ready_out, sw_error_out, dap_ready_out, bus_sel_out, bus_write_out, bus_external_out;
  wire logic [31:0] sw_rdata_out, dap_rdata_out, debug_bus_address_out, bus_wdata_out;
  wire logic [3:0]  debug_enable_out;
  int bad_count = 0, checks_done = 0;
  dvf_view_filter u_dvf_view_filter (.*);
  dvf_bus_model u_dvf_bus_model (.clk_in(clk_in), .sel_in(bus_sel_out), .write_in(bus_write_out),
    .addr_in(debug_bus_address_out), .wdata_in(bus_wdata_out), .rdata_out(bus_rdata_in));
  always #50 clk_in = ~clk_in;
  task automatic cmp(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_go(input logic w, p, input logic [31:0] a, d);
    @(negedge clk_in);
    {sw_req_in, sw_write_in, sw_priv_in, sw_addr_in, sw_wdata_in} = {1'b1, w, p, a, d};
    @(negedge clk_in);
    sw_req_in = 1'b0;
  endtask
  task automatic dap_go(input logic w, input logic [31:0] a, d);
    @(negedge clk_in);
    {dap_req_in, dap_write_in, dap_addr_in, dap_wdata_in} = {1'b1, w, a, d};
    @(negedge clk_in);
    dap_req_in = 1'b0;
  endtask
  task automatic dap_rd(input logic [31:0] a, exp);
    dap_go(1'b0, a, 32'h0);
    @(negedge clk_in);
    cmp("dap read", exp, dap_rdata_out);
  endtask
  task automatic t_views;
    dap_go(1'b1, 32'h80000010, 32'h0000A0A0);
    dap_go(1'b1, 32'h00000010, 32'h0000B0B0);
    sw_go(1'b1, 1'b1, 32'h80000014, 32'h0000C0C0);
    dap_rd(32'h80000010, 32'h0000A0A0);
    dap_rd(32'h00000010, 32'h0000B0B0);
    dap_rd(32'h00000014, 32'h0000C0C0);
    sw_go(1'b0, 1'b1, 32'h80000010, 32'h0);
    @(negedge clk_in);
    cmp("sw read", 32'h0000B0B0, sw_rdata_out);
  endtask
  task automatic t_priv;
    sw_go(1'b1, 1'b0, 32'h00000014, 32'h0000DEAD);
    cmp("sw error", 32'h1, {31'h0, sw_error_out});
    dap_rd(32'h00000014, 32'h0000C0C0);
    cached_system_in = 1'b1;
    sw_nonsecure_in = 1'b1;
    sw_go(1'b1, 1'b0, 32'h00000014, 32'h00005A5A);
    cmp("sw error", 32'h0, {31'h0, sw_error_out});
    dap_rd(32'h00000014, 32'h00005A5A);
    sw_go(1'b0, 1'b1, 32'h00000014, 32'h0);
    @(negedge clk_in);
    cmp("sw read", 32'h00005A5A, sw_rdata_out);
  endtask
  task automatic t_arb;
    @(negedge clk_in);
    cmp("sw ready", 32'h1, {31'h0, sw_ready_out});
    {sw_req_in, sw_write_in, sw_priv_in, sw_addr_in, sw_wdata_in} = {3'b111, 32'h00000018, 32'h00001111};
    {dap_req_in, dap_write_in, dap_addr_in, dap_wdata_in} = {2'b11, 32'h00000018, 32'h00002222};
    #1;
    cmp("sw ready", 32'h0, {31'h0, sw_ready_out});
    cmp("dap ready", 32'h1, {31'h0, dap_ready_out});
    @(negedge clk_in);
    sw_req_in = 1'b0;
    dap_req_in = 1'b0;
    dap_rd(32'h00000018, 32'h00002222);
    sw_go(1'b1, 1'b1, 32'h80000018, 32'h00003333);
    dap_rd(32'h00000018, 32'h00003333);
  endtask
  task automatic t_reset;
    @(negedge clk_in);
    arst_n_in = 1'b0;
    @(posedge clk_in);
    cmp("sw rdata", 32'h0, sw_rdata_out);
    cmp("dap rdata", 32'h0, dap_rdata_out);
    cmp("enables", 32'h2, {28'h0, debug_enable_out});
    @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    cmp("enables", 32'h6, {28'h0, debug_enable_out});
  endtask
  task automatic t_auth;
    auth_mode_in = {`DVF_AUTH_MODULE, `DVF_AUTH_FUSE, `DVF_AUTH_TIED_HIGH, `DVF_AUTH_TIED_LOW};
    repeat (3) @(negedge clk_in);
    cmp("enables", 32'h6, {28'h0, debug_enable_out});
    sw_go(1'b1, 1'b1, 32'h0000F000, 32'h0);
    sw_go(1'b0, 1'b1, 32'h0000F000, 32'h0);
    @(negedge clk_in);
    ch = sw_rdata_out ^ device_key_in;
    sw_go(1'b1, 1'b1, 32'h0000F004, ch);
    @(negedge clk_in);
    cmp("enables", 32'hE, {28'h0, debug_enable_out});
    sw_go(1'b1, 1'b1, 32'h0000F008, 32'h0);
    @(negedge clk_in);
    cmp("enables", 32'h6, {28'h0, debug_enable_out});
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk_in);
    arst_n_in = 1'b1;
    t_views;
    t_priv;
    t_auth;
    t_arb;
    t_reset;
    give_verdict;
  end
  initial
  begin
    repeat (400) @(posedge clk_in);
    bad_count++;
    give_verdict;
  end
endmodule // dvf_view_filter_bench
`default_nettype wire
